// >>> rtl/fcp_pkg.sv
// Constants and carrier types for the flash configuration and protection block
`default_nettype none

package fcp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned     REG_ADDR_W           = 4;
  localparam logic [3:0]      FLASH_CONFIG_OFS     = 4'h3;
  localparam logic [3:0]      FLASH_PROTECTION_OFS = 4'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned     CFG_CBE_IRQ_EN_BIT   = 7;
  localparam int unsigned     CFG_CC_IRQ_EN_BIT    = 6;
  localparam int unsigned     CFG_KEY_ACCESS_BIT   = 5;
  localparam int unsigned     CFG_DF_IRQ_EN_BIT    = 3;
  localparam int unsigned     PROT_FUNCTION_BIT    = 7;
  localparam int unsigned     PROT_RNV_BIT         = 6;
  localparam int unsigned     PROT_HIGH_DIS_BIT    = 5;
  localparam int unsigned     PROT_HIGH_SIZE_LSB   = 3;
  localparam int unsigned     PROT_LOW_DIS_BIT     = 2;
  localparam int unsigned     PROT_LOW_SIZE_LSB    = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  // Whole block protected: function bit clear, all others set
  localparam logic [7:0]      PROT_FULL            = 8'h7f;
  localparam logic [15:0]     NV_PROT_ADDR         = 16'hff0d;
  localparam logic [1:0]      BACKDOOR_KEY_ENABLE_ENABLED        = 2'h2;
  localparam logic [15:0]     LOW_RANGE_BASE       = 16'h4000;
  localparam logic [15:0]     HIGH_RANGE_MIN_SIZE  = 16'h0800;
  localparam logic [15:0]     LOW_RANGE_MIN_SIZE   = 16'h0400;
  // Allowed target scenarios per source scenario, bit j = target j
  localparam logic [7:0][7:0] SCEN_ALLOWED = {8'hff, 8'h5a, 8'h3c, 8'h18,
                                             8'h08, 8'h0c, 8'h0a, 8'h0f};

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } fcp_reg_req_t;

  typedef struct packed {
    logic        cbe_irq_en;
    logic        cc_irq_en;
    logic        key_access;
    logic        df_irq_en;
  } fcp_cfg_t;

  typedef struct packed {
    logic        cmd_buffer_empty_flag;
    logic        cmd_complete_flag;
    logic        double_fault_flag;
  } fcp_flags_t;

  typedef struct packed {
    logic        req;
    logic        mass;
    logic [15:0] addr;
  } fcp_op_req_t;

  typedef struct packed {
    logic        valid;
    logic        double_fault;
    logic [7:0]  data;
  } fcp_nv_resp_t;

endpackage

`default_nettype wire

// >>> rtl/fcp_prot_check.sv
// Address protection decode from the protection register
`default_nettype none

module fcp_prot_check (
  // Protection setting
  input  wire logic [7:0]  prot_in,
  // Address under test
  input  wire logic [15:0] addr_in,
  // Results
  output logic             addr_protected_out,
  output logic             any_protected_out
);
  logic        pf;
  logic        hdis;
  logic        ldis;
  logic [15:0] hsize;
  logic [15:0] lsize;
  logic        in_high;
  logic        in_low;
  logic        in_range;

  always_comb begin
    pf    = prot_in[fcp_pkg::PROT_FUNCTION_BIT];
    hdis  = prot_in[fcp_pkg::PROT_HIGH_DIS_BIT];
    ldis  = prot_in[fcp_pkg::PROT_LOW_DIS_BIT];
    hsize = fcp_pkg::HIGH_RANGE_MIN_SIZE << prot_in[fcp_pkg::PROT_HIGH_SIZE_LSB +: 2];
    lsize = fcp_pkg::LOW_RANGE_MIN_SIZE << prot_in[fcp_pkg::PROT_LOW_SIZE_LSB +: 2];
    // Wraps at 64K so the high range ends at the top address
    in_high  = addr_in >= (16'h0000 - hsize);
    in_low   = (addr_in - fcp_pkg::LOW_RANGE_BASE) < lsize;
    in_range = (!hdis && in_high) || (!ldis && in_low);
    addr_protected_out = pf ? in_range : !in_range;
    any_protected_out  = !(pf && hdis && ldis);
  end
endmodule

`default_nettype wire

// >>> rtl/fcp_nv_loader.sv
// Reset-time fetch of the protection byte from nonvolatile configuration
`default_nettype none

module fcp_nv_loader (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Nonvolatile read port
  output logic                      nv_rd_req_out,
  output logic [15:0]               nv_addr_out,
  input  wire fcp_pkg::fcp_nv_resp_t nv_resp_in,
  // Result
  output logic                      load_valid_out,
  output logic [7:0]                load_data_out
);
  typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} fcp_ld_state_t;

  typedef struct packed {
    fcp_ld_state_t state;
    logic          req;
    logic          valid;
    logic [7:0]    data;
  } fcp_ld_t;

  fcp_ld_t st_reg;
  fcp_ld_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.req   = 1'b0;
    st_next.valid = 1'b0;
    unique case (st_reg.state)
      LD_REQ: begin
        st_next.req   = 1'b1;
        st_next.state = LD_WAIT;
      end
      LD_WAIT: begin
        if (nv_resp_in.valid) begin
          // Unreadable byte falls back to the safest setting
          st_next.data  = nv_resp_in.double_fault ? fcp_pkg::PROT_FULL : nv_resp_in.data;
          st_next.valid = 1'b1;
          st_next.state = LD_DONE;
        end
      end
      LD_DONE: begin
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '{state: LD_REQ, req: 1'b0, valid: 1'b0, data: fcp_pkg::PROT_FULL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign nv_rd_req_out  = st_reg.req;
  assign nv_addr_out    = fcp_pkg::NV_PROT_ADDR;
  assign load_valid_out = st_reg.valid;
  assign load_data_out  = st_reg.data;
endmodule

`default_nettype wire

// >>> rtl/fcp_top.sv
// Flash configuration and protection registers with access gating
//
// Function
// - Buffer-empty enable passes buffer-empty flag to interrupt
// - Complete enable passes command-complete flag to interrupt
// - Double-fault enable passes double-fault flag to interrupt
// - Key access: array writes are keys, reads invalid
// - No key access: array write starts command
// - Key access writable only with backdoor enabled
// - Config: four bits read/write, rest read zero
// - Protection loaded from nonvolatile byte at reset
// - Double fault at load: full block protected
// - Protected program/erase refused, violation flag set
// - Mass erase refused if anything protected
// - Reserved nonvolatile protection bit is read-only
// - High size writable only while high disabled
// - Low size writable only while low disabled
// - Function bit set: enabled ranges are protected
// - Function bit clear: enabled ranges unprotected, rest protected
// - Clear function, both disabled: all protected
// - Disable bit removes range at its end
// - High size 2/4/8/16 KB ending at top
// - Low size 1/2/4/8 KB from 0x4000
// - Write to disallowed scenario is ignored
//
// The strobed register port was chosen for this implementation.
`default_nettype none

module fcp_top #(
  parameter int unsigned ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Register port
  input  wire fcp_pkg::fcp_reg_req_t reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  // Status flags and security field
  input  wire fcp_pkg::fcp_flags_t   flags_in,
  input  wire logic [1:0]            backdoor_key_enable_in,
  // Flash array access
  input  wire logic                  array_wr_in,
  output logic                       key_write_out,
  output logic                       cmd_start_out,
  output logic                       array_rd_invalid_out,
  // Program and erase requests
  input  wire fcp_pkg::fcp_op_req_t  op_req_in,
  output logic                       op_accept_out,
  output logic                       protection_violation_flag_out,
  // Nonvolatile read port
  output logic                       nv_rd_req_out,
  output logic [15:0]                nv_addr_out,
  input  wire fcp_pkg::fcp_nv_resp_t nv_resp_in,
  // Status
  output logic                       load_done_out,
  output logic                       flash_irq_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("fcp_top supports only a 16-bit unpaged address");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fcp_pkg::fcp_cfg_t cfg;
    logic [7:0]        prot;
    logic              loaded;
    logic [7:0]        rdata;
    logic              irq;
    logic              key_wr;
    logic              cmd_start;
    logic              accept;
    logic              viol;
  } fcp_top_state_t;

  fcp_top_state_t st_reg;
  fcp_top_state_t st_next;

  logic       load_valid;
  logic [7:0] load_data;
  logic       addr_protected;
  logic       any_protected;
  logic [7:0] prot_cand;
  logic [2:0] scen_cur;
  logic [2:0] scen_new;
  logic       scen_ok;
  logic [7:0] cfg_rd;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  fcp_nv_loader u_loader (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .nv_rd_req_out  (nv_rd_req_out),
    .nv_addr_out    (nv_addr_out),
    .nv_resp_in     (nv_resp_in),
    .load_valid_out (load_valid),
    .load_data_out  (load_data)
  );

  fcp_prot_check u_check (
    .prot_in            (st_reg.prot),
    .addr_in            (op_req_in.addr),
    .addr_protected_out (addr_protected),
    .any_protected_out  (any_protected)
  );

  // ----------------------------------------------------------------
  // Write candidates
  // ----------------------------------------------------------------
  always_comb begin
    prot_cand = st_reg.prot;
    prot_cand[fcp_pkg::PROT_FUNCTION_BIT] = reg_req_in.wdata[fcp_pkg::PROT_FUNCTION_BIT];
    prot_cand[fcp_pkg::PROT_HIGH_DIS_BIT] = reg_req_in.wdata[fcp_pkg::PROT_HIGH_DIS_BIT];
    prot_cand[fcp_pkg::PROT_LOW_DIS_BIT]  = reg_req_in.wdata[fcp_pkg::PROT_LOW_DIS_BIT];
    if (st_reg.prot[fcp_pkg::PROT_HIGH_DIS_BIT]) begin
      prot_cand[fcp_pkg::PROT_HIGH_SIZE_LSB +: 2] = reg_req_in.wdata[fcp_pkg::PROT_HIGH_SIZE_LSB +: 2];
    end
    if (st_reg.prot[fcp_pkg::PROT_LOW_DIS_BIT]) begin
      prot_cand[fcp_pkg::PROT_LOW_SIZE_LSB +: 2] = reg_req_in.wdata[fcp_pkg::PROT_LOW_SIZE_LSB +: 2];
    end
    scen_cur = {st_reg.prot[fcp_pkg::PROT_FUNCTION_BIT], st_reg.prot[fcp_pkg::PROT_HIGH_DIS_BIT],
                st_reg.prot[fcp_pkg::PROT_LOW_DIS_BIT]};
    scen_new = {prot_cand[fcp_pkg::PROT_FUNCTION_BIT], prot_cand[fcp_pkg::PROT_HIGH_DIS_BIT],
                prot_cand[fcp_pkg::PROT_LOW_DIS_BIT]};
    scen_ok  = fcp_pkg::SCEN_ALLOWED[scen_cur][scen_new];
    cfg_rd   = '0;
    cfg_rd[fcp_pkg::CFG_CBE_IRQ_EN_BIT] = st_reg.cfg.cbe_irq_en;
    cfg_rd[fcp_pkg::CFG_CC_IRQ_EN_BIT]  = st_reg.cfg.cc_irq_en;
    cfg_rd[fcp_pkg::CFG_KEY_ACCESS_BIT] = st_reg.cfg.key_access;
    cfg_rd[fcp_pkg::CFG_DF_IRQ_EN_BIT]  = st_reg.cfg.df_irq_en;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.rdata     = '0;
    st_next.key_wr    = 1'b0;
    st_next.cmd_start = 1'b0;
    st_next.accept    = 1'b0;
    st_next.viol      = 1'b0;

    // Register reads, unmapped offsets read zero
    if (reg_req_in.rd) begin
      if (reg_req_in.addr == fcp_pkg::FLASH_CONFIG_OFS) begin
        st_next.rdata = cfg_rd;
      end else if (reg_req_in.addr == fcp_pkg::FLASH_PROTECTION_OFS) begin
        st_next.rdata = st_reg.prot;
      end
    end

    // Configuration writes
    if (reg_req_in.wr && reg_req_in.addr == fcp_pkg::FLASH_CONFIG_OFS) begin
      st_next.cfg.cbe_irq_en = reg_req_in.wdata[fcp_pkg::CFG_CBE_IRQ_EN_BIT];
      st_next.cfg.cc_irq_en  = reg_req_in.wdata[fcp_pkg::CFG_CC_IRQ_EN_BIT];
      st_next.cfg.df_irq_en  = reg_req_in.wdata[fcp_pkg::CFG_DF_IRQ_EN_BIT];
      if (backdoor_key_enable_in == fcp_pkg::BACKDOOR_KEY_ENABLE_ENABLED) begin
        st_next.cfg.key_access = reg_req_in.wdata[fcp_pkg::CFG_KEY_ACCESS_BIT];
      end
    end

    // Protection writes; ignored until the reset load has landed
    if (reg_req_in.wr && reg_req_in.addr == fcp_pkg::FLASH_PROTECTION_OFS && st_reg.loaded && scen_ok) begin
      st_next.prot = prot_cand;
    end
    if (load_valid) begin
      st_next.prot   = load_data;
      st_next.loaded = 1'b1;
    end

    // Interrupt request
    st_next.irq = (st_reg.cfg.cbe_irq_en && flags_in.cmd_buffer_empty_flag) ||
                  (st_reg.cfg.cc_irq_en && flags_in.cmd_complete_flag) ||
                  (st_reg.cfg.df_irq_en && flags_in.double_fault_flag);

    // Array writes
    if (array_wr_in) begin
      st_next.key_wr    = st_reg.cfg.key_access;
      st_next.cmd_start = !st_reg.cfg.key_access;
    end

    // Program and erase requests
    if (op_req_in.req) begin
      if (op_req_in.mass ? any_protected : addr_protected) begin
        st_next.viol = 1'b1;
      end else begin
        st_next.accept = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Until the load lands the block counts as fully protected
      st_reg <= '{cfg: '0, prot: fcp_pkg::PROT_FULL, loaded: 1'b0, rdata: '0, irq: 1'b0,
                  key_wr: 1'b0, cmd_start: 1'b0, accept: 1'b0, viol: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out                 = st_reg.rdata;
  assign key_write_out                 = st_reg.key_wr;
  assign cmd_start_out                 = st_reg.cmd_start;
  assign array_rd_invalid_out          = st_reg.cfg.key_access;
  assign op_accept_out                 = st_reg.accept;
  assign protection_violation_flag_out = st_reg.viol;
  assign load_done_out                 = st_reg.loaded;
  assign flash_irq_out                 = st_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_cfg_write;
    reg_req_in.wr && reg_req_in.addr == fcp_pkg::FLASH_CONFIG_OFS;
  endsequence

  sequence s_prot_write;
    reg_req_in.wr && reg_req_in.addr == fcp_pkg::FLASH_PROTECTION_OFS && load_done_out && !load_valid;
  endsequence

  sequence s_cfg_read;
    reg_req_in.rd && reg_req_in.addr == fcp_pkg::FLASH_CONFIG_OFS;
  endsequence

  sequence s_prot_read;
    reg_req_in.rd && reg_req_in.addr == fcp_pkg::FLASH_PROTECTION_OFS;
  endsequence

  sequence s_key_write;
    s_cfg_write and (backdoor_key_enable_in == fcp_pkg::BACKDOOR_KEY_ENABLE_ENABLED);
  endsequence

  AST_IRQ_CBE: assert property (
    st_reg.cfg.cbe_irq_en && flags_in.cmd_buffer_empty_flag |=> flash_irq_out)
    else $error("buffer empty interrupt missing");
  AST_IRQ_CC: assert property (
    st_reg.cfg.cc_irq_en && flags_in.cmd_complete_flag |=> flash_irq_out)
    else $error("command complete interrupt missing");
  AST_IRQ_DF: assert property (
    st_reg.cfg.df_irq_en && flags_in.double_fault_flag |=> flash_irq_out)
    else $error("double fault interrupt missing");
  AST_IRQ_MASK: assert property (
    !((st_reg.cfg.cbe_irq_en && flags_in.cmd_buffer_empty_flag) ||
      (st_reg.cfg.cc_irq_en && flags_in.cmd_complete_flag) ||
      (st_reg.cfg.df_irq_en && flags_in.double_fault_flag)) |=> !flash_irq_out)
    else $error("interrupt raised with all sources masked");
  AST_KEY_ROUTE: assert property (
    array_wr_in && array_rd_invalid_out |=> key_write_out && !cmd_start_out)
    else $error("key write not routed");
  AST_CMD_ROUTE: assert property (
    array_wr_in && !array_rd_invalid_out |=> cmd_start_out && !key_write_out)
    else $error("command start not routed");
  AST_KEY_LOCK: assert property (
    backdoor_key_enable_in != fcp_pkg::BACKDOOR_KEY_ENABLE_ENABLED |=> $stable(array_rd_invalid_out))
    else $error("key access changed while backdoor disabled");
  AST_CFG_READ: assert property (
    s_cfg_write ##1 s_cfg_read |=>
      reg_rdata_out[fcp_pkg::CFG_CBE_IRQ_EN_BIT] == $past(reg_req_in.wdata[fcp_pkg::CFG_CBE_IRQ_EN_BIT], 2)
      && reg_rdata_out[2:0] == 3'h0 && reg_rdata_out[4] == 1'b0)
    else $error("config readback wrong");
  AST_RNV_RO: assert property (
    s_prot_write |=> $stable(st_reg.prot[fcp_pkg::PROT_RNV_BIT]))
    else $error("reserved protection bit changed by write");
  AST_HSIZE_LOCK: assert property (
    (s_prot_write and !st_reg.prot[fcp_pkg::PROT_HIGH_DIS_BIT]) |=>
      $stable(st_reg.prot[fcp_pkg::PROT_HIGH_SIZE_LSB +: 2]))
    else $error("high size changed while range enabled");
  AST_LSIZE_LOCK: assert property (
    (s_prot_write and !st_reg.prot[fcp_pkg::PROT_LOW_DIS_BIT]) |=>
      $stable(st_reg.prot[fcp_pkg::PROT_LOW_SIZE_LSB +: 2]))
    else $error("low size changed while range enabled");
  AST_SCEN_REJECT: assert property (
    (s_prot_write and !scen_ok) |=> $stable(st_reg.prot))
    else $error("disallowed scenario accepted");
  AST_LOAD: assert property (
    load_valid |=> load_done_out && st_reg.prot == $past(load_data))
    else $error("protection byte not loaded");
  AST_LOAD_BOUND: assert property (
    nv_rd_req_out |-> nv_addr_out == fcp_pkg::NV_PROT_ADDR)
    else $error("wrong nonvolatile address");
  AST_VIOL: assert property (
    op_req_in.req && !op_req_in.mass && addr_protected |=> protection_violation_flag_out && !op_accept_out)
    else $error("protected program not refused");
  AST_MASS: assert property (
    op_req_in.req && op_req_in.mass && any_protected |=> !op_accept_out)
    else $error("mass erase accepted with protection");
  AST_FULL_PROT: assert property (
    op_req_in.req && st_reg.prot[7:5] == 3'h3 && st_reg.prot[2] |=> !op_accept_out)
    else $error("access accepted with full block protected");
  AST_RDATA_IDLE: assert property (
    !reg_req_in.rd |=> reg_rdata_out == 8'h00)
    else $error("read data not cleared");
  AST_CFG_ZERO: assert property (
    s_cfg_read |=> reg_rdata_out[2:0] == 3'h0 && !reg_rdata_out[4])
    else $error("unused config bits not zero");
  AST_PROT_READ: assert property (
    s_prot_read |=> reg_rdata_out == $past(st_reg.prot))
    else $error("protection readback wrong");
  AST_RNV_HOLD: assert property (
    !load_valid |=> $stable(st_reg.prot[fcp_pkg::PROT_RNV_BIT]))
    else $error("reserved protection bit changed");
  AST_KEY_SET: assert property (
    s_key_write |=> array_rd_invalid_out == $past(reg_req_in.wdata[fcp_pkg::CFG_KEY_ACCESS_BIT]))
    else $error("key access write not taken");
  AST_SCEN_TAKE: assert property (
    (s_prot_write and scen_ok) |=>
      st_reg.prot[fcp_pkg::PROT_FUNCTION_BIT] == $past(reg_req_in.wdata[fcp_pkg::PROT_FUNCTION_BIT]))
    else $error("allowed scenario not taken");
  AST_ARRAY_IDLE: assert property (
    !array_wr_in |=> !key_write_out && !cmd_start_out)
    else $error("array pulse without array write");
  AST_OP_ONE: assert property (
    op_req_in.req |=> op_accept_out != protection_violation_flag_out)
    else $error("request not answered exactly once");
  AST_OP_IDLE: assert property (
    !op_req_in.req |=> !op_accept_out && !protection_violation_flag_out)
    else $error("answer without request");
  AST_OPEN_ALL: assert property (
    op_req_in.req && st_reg.prot[fcp_pkg::PROT_FUNCTION_BIT] && st_reg.prot[fcp_pkg::PROT_HIGH_DIS_BIT] &&
      st_reg.prot[fcp_pkg::PROT_LOW_DIS_BIT] |=> op_accept_out)
    else $error("access refused with nothing protected");
  AST_LOW_OPEN: assert property (
    op_req_in.req && !op_req_in.mass && op_req_in.addr == fcp_pkg::LOW_RANGE_BASE &&
      !st_reg.prot[fcp_pkg::PROT_FUNCTION_BIT] && !st_reg.prot[fcp_pkg::PROT_LOW_DIS_BIT] |=> op_accept_out)
    else $error("unprotected low range refused");
  AST_PRE_LOAD: assert property (
    !load_done_out && !load_valid |=> st_reg.prot == fcp_pkg::PROT_FULL)
    else $error("protection open before load");

endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the flash configuration and protection block
`default_nettype none
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and device
  // ----------------------------------------------------------------
  logic                  clk_in                 = 1'b0;
  logic                  rst_in                 = 1'b1;
  fcp_pkg::fcp_reg_req_t reg_req_in             = '0;
  logic [7:0]            reg_rdata_out;
  fcp_pkg::fcp_flags_t   flags_in               = '0;
  logic [1:0]            backdoor_key_enable_in = 2'h0;
  logic                  array_wr_in            = 1'b0;
  logic                  key_write_out;
  logic                  cmd_start_out;
  logic                  array_rd_invalid_out;
  fcp_pkg::fcp_op_req_t  op_req_in              = '0;
  logic                  op_accept_out;
  logic                  protection_violation_flag_out;
  logic                  nv_rd_req_out;
  logic [15:0]           nv_addr_out;
  fcp_pkg::fcp_nv_resp_t nv_resp_in             = '0;
  logic                  load_done_out;
  logic                  flash_irq_out;
  int                    miscompares            = 0;
  int                    n_tests                = 0;
  int                    cycles                 = 0;
  logic [7:0]            en [3]                 = '{8'h80, 8'h40, 8'h08};
  logic [2:0]            fb [3]                 = '{3'h4, 3'h2, 3'h1};

  always #10 clk_in = ~clk_in;

  fcp_top #(.ADDR_W(16)) uut (
    .clk_in                        (clk_in),
    .rst_in                        (rst_in),
    .reg_req_in                    (reg_req_in),
    .reg_rdata_out                 (reg_rdata_out),
    .flags_in                      (flags_in),
    .backdoor_key_enable_in        (backdoor_key_enable_in),
    .array_wr_in                   (array_wr_in),
    .key_write_out                 (key_write_out),
    .cmd_start_out                 (cmd_start_out),
    .array_rd_invalid_out          (array_rd_invalid_out),
    .op_req_in                     (op_req_in),
    .op_accept_out                 (op_accept_out),
    .protection_violation_flag_out (protection_violation_flag_out),
    .nv_rd_req_out                 (nv_rd_req_out),
    .nv_addr_out                   (nv_addr_out),
    .nv_resp_in                    (nv_resp_in),
    .load_done_out                 (load_done_out),
    .flash_irq_out                 (flash_irq_out)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic results;
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in) reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in) reg_req_in <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in) reg_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in) reg_req_in <= '0;
    #1 `CHK(reg_rdata_out, e)
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_in) reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in) reg_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in) reg_req_in <= '0;
    #1 `CHK(reg_rdata_out, e)
  endtask

  task automatic op(input logic [15:0] a, input logic m, input logic acc);
    @(posedge clk_in) op_req_in <= '{req: 1'b1, mass: m, addr: a};
    @(posedge clk_in) op_req_in <= '0;
    #1 `CHK(op_accept_out, acc)
    `CHK(protection_violation_flag_out, ~acc)
  endtask

  task automatic aw(input logic key);
    @(posedge clk_in) array_wr_in <= 1'b1;
    @(posedge clk_in) array_wr_in <= 1'b0;
    #1 `CHK(key_write_out, key)
    `CHK(cmd_start_out, ~key)
    `CHK(array_rd_invalid_out, key)
  endtask

  task automatic fl(input logic [2:0] f, input logic e);
    @(posedge clk_in) flags_in <= f;
    @(posedge clk_in) #1 `CHK(flash_irq_out, e)
  endtask

  // Reset, early accesses, then answer the fetch; idle data is the inverse
  task automatic boot(input logic [7:0] d, input logic df, input logic [7:0] e);
    @(posedge clk_in) rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in) #1 `CHK(nv_rd_req_out, 1'b1)
    `CHK(nv_addr_out, 16'hff0d)
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h7f);
    rd(4'h3, 8'h00);
    @(posedge clk_in) nv_resp_in <= '{valid: 1'b1, double_fault: df, data: d};
    @(posedge clk_in) nv_resp_in <= '{valid: 1'b0, double_fault: 1'b0, data: ~d};
    #1 `CHK(load_done_out, 1'b0)
    @(posedge clk_in) #1 `CHK(load_done_out, 1'b1)
    rd(4'h4, e);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    boot(8'hff, 1'b0, 8'hff);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in) backdoor_key_enable_in <= 2'h2;
      wr(4'h3, 8'h00);
      @(posedge clk_in) backdoor_key_enable_in <= k[1:0];
      wrrd(4'h3, 8'hff, (k == 2) ? 8'he8 : 8'hc8);
    end
    aw(1'b0);
    @(posedge clk_in) backdoor_key_enable_in <= 2'h2;
    wr(4'h3, 8'h20);
    aw(1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(4'h3, en[i]);
      fl(~fb[i], 1'b0);
      fl(fb[i], 1'b1);
    end
    fl(3'h0, 1'b0);
    op(16'h4000, 1'b0, 1'b1);
    op(16'hffff, 1'b1, 1'b1);
    wrrd(4'h4, 8'hf7, 8'hf7);
    wrrd(4'h4, 8'hd3, 8'hd3);
    op(16'hdfff, 1'b0, 1'b1);
    op(16'he000, 1'b0, 1'b0);
    op(16'h5fff, 1'b0, 1'b0);
    op(16'h6000, 1'b0, 1'b1);
    op(16'h0000, 1'b1, 1'b0);
    wrrd(4'h4, 8'h80, 8'hd3);
    wrrd(4'h4, 8'h13, 8'hd3);
    wrrd(4'h4, 8'h7f, 8'h77);
    op(16'h8000, 1'b0, 1'b0);
    wrrd(4'h8, 8'hff, 8'h00);
    rd(4'h3, 8'h08);
    boot(8'h53, 1'b0, 8'h53);
    op(16'he000, 1'b0, 1'b1);
    op(16'h4000, 1'b0, 1'b1);
    op(16'h5fff, 1'b0, 1'b1);
    op(16'h6000, 1'b0, 1'b0);
    op(16'hdfff, 1'b0, 1'b0);
    boot(8'hff, 1'b1, 8'h7f);
    op(16'hf800, 1'b0, 1'b0);
    results();
  end

endmodule

`default_nettype wire
